// ===== hw/sas_pkg.sv
package sas_pkg;
  localparam int RES_W = 12;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int SAR_CYCLES = 18;
  localparam int CLK_MHZ = 40;
  localparam int SAR_CLK_MAX_MHZ = 18;
  localparam int SAR_DIV = (CLK_MHZ + SAR_CLK_MAX_MHZ - 1) / SAR_CLK_MAX_MHZ;
  localparam int SAMP_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_CHEN = 6'h01;
  localparam logic [ADDR_W-1:0] OFF_FWSEL = 6'h02;
  localparam logic [ADDR_W-1:0] OFF_LIMLO = 6'h03;
  localparam logic [ADDR_W-1:0] OFF_LIMHI = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_STAT = 6'h05;
  localparam logic [ADDR_W-1:0] OFF_MASK = 6'h06;
  localparam logic [ADDR_W-1:0] OFF_STATE = 6'h07;
  localparam logic [ADDR_W-1:0] OFF_SAMP = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_RES = 6'h20;
  localparam int CTRL_EN = 0;
  localparam int CTRL_FW = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_START = 3;
  localparam int CTRL_REF = 4;
  localparam int CTRL_TEMP = 6;
  localparam int CTRL_LP = 7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_RANGE = 1;
  localparam int IRQ_SCAN = 2;
  localparam logic [7:0] SAMP_RST = 8'h02;
  localparam logic [11:0] LIMHI_RST = 12'hFFF;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } sas_state_e;
endpackage

// ===== hw/sas_sar_core.sv
`timescale 1ns/1ps
module sas_sar_core (
  input  wire logic                      core_clk_in,
  input  wire logic                      srst_in,
  input  wire logic                      start_in,
  input  wire logic                      cmp_in,
  output logic                           sar_clk_out,
  output logic [sas_pkg::RES_W-1:0]      dac_out,
  output logic                           busy_out,
  output logic                           done_out,
  output logic [sas_pkg::RES_W-1:0]      result_out
);
  logic [3:0]                   div_q;
  logic [4:0]                   cyc_q;
  logic [sas_pkg::RES_W-1:0]    trial_q;
  logic [sas_pkg::RES_W-1:0]    bit_q;
  logic                         tick;
  logic                         last_cyc;
  logic                         cmp_s1_q;
  logic                         cmp_s2_q;
  // sar clock never exceeds its limit: core clock is divided down
  assign tick = (div_q == 4'(sas_pkg::SAR_DIV - 1));
  assign last_cyc = tick && (cyc_q == 5'(sas_pkg::SAR_CYCLES - 1));
  assign sar_clk_out = busy_out && (div_q < 4'(sas_pkg::SAR_DIV / 2));
  assign dac_out = trial_q | bit_q;
  always_ff @(posedge core_clk_in)
  begin
    cmp_s1_q <= cmp_in;
    cmp_s2_q <= cmp_s1_q;
    done_out <= 1'b0;
    if (srst_in)
    begin
      div_q <= 4'h0;
      cyc_q <= 5'h00;
      trial_q <= 12'h000;
      bit_q <= 12'h000;
      busy_out <= 1'b0;
      result_out <= 12'h000;
    end
    else if (start_in && !busy_out)
    begin
      busy_out <= 1'b1;
      div_q <= 4'h0;
      cyc_q <= 5'h00;
      trial_q <= 12'h000;
      bit_q <= 12'h800;
    end
    else if (busy_out)
    begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      if (tick)
      begin
        cyc_q <= cyc_q + 5'h01;
        // one bit decided per sar clock, rest of the 18 are settle/latch
        if (bit_q != 12'h000)
        begin
          if (cmp_s2_q)
            trial_q <= trial_q | bit_q;
          bit_q <= bit_q >> 1;
        end
        if (last_cyc)
        begin
          busy_out <= 1'b0;
          done_out <= 1'b1;
          result_out <= trial_q;
        end
      end
    end
  end
endmodule // sas_sar_core

// ===== hw/sas_seq.sv
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module sas_seq (
  input  wire logic                         core_clk_in,
  input  wire logic                         srst_in,
  input  wire logic [sas_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [sas_pkg::DATA_W-1:0]   wdata_in,
  input  wire logic                         wr_in,
  input  wire logic                         rd_in,
  output logic      [sas_pkg::DATA_W-1:0]   rdata_out,
  input  wire logic                         deep_lp_in,
  input  wire logic                         cmp_in,
  output logic                              sar_clk_out,
  output logic      [sas_pkg::RES_W-1:0]    dac_out,
  output logic      [sas_pkg::CH_W-1:0]     mux_sel_out,
  output logic                              temp_sel_out,
  output logic                              sample_out,
  output logic      [1:0]                   ref_sel_out,
  output logic                              irq_out
);
  localparam int N = sas_pkg::NUM_CH;
  logic [7:0]                 ctrl_q;
  logic [N-1:0]               chen_q;
  logic [2:0]                 fwsel_q;
  logic [11:0]                limlo_q;
  logic [11:0]                limhi_q;
  logic [2:0]                 stat_q;
  logic [2:0]                 mask_q;
  logic [7:0]                 samp_q [N];
  logic [11:0]                res_q [N];
  logic [N-1:0]               valid_q;
  sas_pkg::sas_state_e        state_q;
  logic [2:0]                 ch_q;
  logic [2:0]                 conv_ch_q;
  logic                       conv_last_q;
  logic [7:0]                 scnt_q;
  logic                       lp_s1_q;
  logic                       lp_s2_q;
  logic                       start_q;
  logic                       core_busy;
  logic                       core_done;
  logic [11:0]                core_res;
  logic                       active;
  logic                       fw_mode;
  logic [2:0]                 next_ch;
  logic                       wrap;
  logic                       out_range;
  logic                       done_ev;
  logic                       range_ev;
  logic                       scan_ev;
  logic [2:0]                 ev_vec;
  logic                       wr_stat;
  logic                       samp_end;
  logic [2:0]                 first_ch;

  // search for the next enabled channel after cur, wrapping round
  function automatic logic [2:0] next_en(input logic [N-1:0] en, input logic [2:0] cur);
    logic [2:0] r;
    logic       hit;
    r = cur;
    hit = 1'b0;
    for (int i = 1; i <= N; i++)
    begin
      if (!hit && en[3'(cur + 3'(i))])
      begin
        r = 3'(cur + 3'(i));
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  // deep-sleep request is an outside level: two flops before use
  always_ff @(posedge core_clk_in)
  begin
    lp_s1_q <= deep_lp_in;
    lp_s2_q <= lp_s1_q;
  end

  assign active = ctrl_q[sas_pkg::CTRL_EN] && !lp_s2_q && !ctrl_q[sas_pkg::CTRL_LP];
  assign fw_mode = ctrl_q[sas_pkg::CTRL_FW];
  assign first_ch = next_en(chen_q, 3'h7);
  assign next_ch = fw_mode ? fwsel_q : next_en(chen_q, ch_q);
  assign wrap = !fw_mode && (next_ch <= ch_q);
  assign samp_end = (scnt_q == 8'h00);
  assign out_range = (core_res < limlo_q) || (core_res > limhi_q);
  assign done_ev = core_done;
  assign range_ev = core_done && out_range;
  // scan completes when the last enabled channel's result lands
  assign scan_ev = core_done && conv_last_q && !fw_mode;
  assign ev_vec = {scan_ev, range_ev, done_ev};
  assign wr_stat = wr_in && (addr_in == sas_pkg::OFF_STAT);
  assign mux_sel_out = ch_q;
  assign temp_sel_out = ctrl_q[sas_pkg::CTRL_TEMP];
  assign ref_sel_out = ctrl_q[sas_pkg::CTRL_REF +: 2];
  assign sample_out = (state_q == sas_pkg::ST_SAMPLE);
  assign irq_out = |(stat_q & mask_q);

  sas_sar_core u_core (
    .core_clk_in (core_clk_in),
    .srst_in     (srst_in),
    .start_in    (start_q),
    .cmp_in      (cmp_in),
    .sar_clk_out (sar_clk_out),
    .dac_out     (dac_out),
    .busy_out    (core_busy),
    .done_out    (core_done),
    .result_out  (core_res)
  );

  // register file
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      ctrl_q <= 8'h00;
      chen_q <= 8'h00;
      fwsel_q <= 3'h0;
      limlo_q <= 12'h000;
      limhi_q <= sas_pkg::LIMHI_RST;
      mask_q <= 3'h0;
      for (int i = 0; i < N; i++)
        samp_q[i] <= sas_pkg::SAMP_RST;
    end
    else if (wr_in)
    begin
      case (addr_in)
        sas_pkg::OFF_CTRL: ctrl_q <= wdata_in[7:0];
        sas_pkg::OFF_CHEN: chen_q <= wdata_in[7:0];
        sas_pkg::OFF_FWSEL: fwsel_q <= wdata_in[2:0];
        sas_pkg::OFF_LIMLO: limlo_q <= wdata_in[11:0];
        sas_pkg::OFF_LIMHI: limhi_q <= wdata_in[11:0];
        sas_pkg::OFF_MASK: mask_q <= wdata_in[2:0];
        default:
        begin
          if (addr_in[5:3] == sas_pkg::OFF_SAMP[5:3])
            samp_q[addr_in[2:0]] <= wdata_in[7:0];
        end
      endcase
    end
    else if (ctrl_q[sas_pkg::CTRL_START] && state_q == sas_pkg::ST_IDLE)
      ctrl_q[sas_pkg::CTRL_START] <= 1'b0;
  end

  // sticky status: hardware set wins over write-one-to-clear
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      stat_q <= 3'h0;
    else
      stat_q <= (stat_q & ~(wr_stat ? wdata_in[2:0] : 3'h0)) | ev_vec;
  end

  // sequencer: sample phase then conversion, next sample overlaps conversion
  always_ff @(posedge core_clk_in)
  begin
    start_q <= 1'b0;
    if (srst_in || !active)
    begin
      state_q <= sas_pkg::ST_IDLE;
      ch_q <= 3'h0;
      conv_ch_q <= 3'h0;
      conv_last_q <= 1'b0;
      scnt_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        sas_pkg::ST_IDLE:
        begin
          if (ctrl_q[sas_pkg::CTRL_START] && (fw_mode || chen_q != 8'h00))
          begin
            ch_q <= fw_mode ? fwsel_q : first_ch;
            scnt_q <= samp_q[fw_mode ? fwsel_q : first_ch];
            state_q <= sas_pkg::ST_SAMPLE;
          end
        end
        sas_pkg::ST_SAMPLE:
        begin
          if (!samp_end)
            scnt_q <= scnt_q - 8'h01;
          else if (!core_busy || core_done)
          begin
            start_q <= 1'b1;
            conv_ch_q <= ch_q;
            state_q <= sas_pkg::ST_CONV;
          end
        end
        sas_pkg::ST_CONV:
        begin
          // sampling the next channel while converting keeps throughput
          conv_last_q <= wrap;
          // single-shot firmware mode converts its channel once
          if ((wrap || fw_mode) && !ctrl_q[sas_pkg::CTRL_CONT])
          begin
            ch_q <= fw_mode ? fwsel_q : first_ch;
            state_q <= sas_pkg::ST_IDLE;
          end
          else
          begin
            ch_q <= next_ch;
            scnt_q <= samp_q[next_ch];
            state_q <= sas_pkg::ST_SAMPLE;
          end
        end
        default: state_q <= sas_pkg::ST_IDLE;
      endcase
    end
  end

  // per-channel result buffers
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      valid_q <= 8'h00;
      for (int i = 0; i < N; i++)
        res_q[i] <= 12'h000;
    end
    else if (core_done)
    begin
      res_q[conv_ch_q] <= core_res;
      valid_q[conv_ch_q] <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
    begin
      case (addr_in)
        sas_pkg::OFF_CTRL: rdata_out <= {24'h0, ctrl_q};
        sas_pkg::OFF_CHEN: rdata_out <= {24'h0, chen_q};
        sas_pkg::OFF_FWSEL: rdata_out <= {29'h0, fwsel_q};
        sas_pkg::OFF_LIMLO: rdata_out <= {20'h0, limlo_q};
        sas_pkg::OFF_LIMHI: rdata_out <= {20'h0, limhi_q};
        sas_pkg::OFF_STAT: rdata_out <= {29'h0, stat_q};
        sas_pkg::OFF_MASK: rdata_out <= {29'h0, mask_q};
        sas_pkg::OFF_STATE: rdata_out <= {16'h0, valid_q, ch_q, core_busy, 2'h0, state_q};
        default:
        begin
          if (addr_in[5:3] == sas_pkg::OFF_SAMP[5:3])
            rdata_out <= {24'h0, samp_q[addr_in[2:0]]};
          else if (addr_in[5:3] == sas_pkg::OFF_RES[5:3])
            rdata_out <= {20'h0, res_q[addr_in[2:0]]};
          else
            rdata_out <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule // sas_seq

// ===== verification/sas_ana_model.sv
`timescale 1ns/1ps
module sas_ana_model (
  input  wire logic        core_clk_in,
  input  wire logic [11:0] dac_in,
  input  wire logic [2:0]  mux_sel_in,
  input  wire logic        temp_sel_in,
  input  wire logic        sample_in,
  output logic             cmp_out
);
  // fixed pin levels so every result is predictable
  logic [11:0] vin;
  logic [11:0] held_q = 12'h000;
  logic [11:0] track_q = 12'h000;
  logic        smp_q = 1'b0;
  assign vin = temp_sel_in ? 12'h7AB : 12'h1F0 + 12'h150 * {9'h000, mux_sel_in};
  // hold cap keeps its level while the next channel is muxed in
  // track while the aperture is open, hold only once it closes
  always @(posedge core_clk_in)
  begin
    smp_q <= sample_in;
    if (sample_in) track_q <= vin;
    if (smp_q && !sample_in) held_q <= track_q;
  end
  assign cmp_out = dac_in <= held_q;
endmodule // sas_ana_model

// ===== verification/sas_seq_chk.sv
`timescale 1ns/1ps
module sas_seq_chk (
  input wire logic        core_clk_in,
  input wire logic        srst_in,
  input wire logic [5:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic        deep_lp_in,
  input wire logic        sar_clk_out,
  input wire logic [2:0]  mux_sel_out,
  input wire logic        sample_out,
  input wire logic [1:0]  ref_sel_out,
  input wire logic        irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_lp_held;
    deep_lp_in [*8];
  endsequence
  sequence s_mask_off;
    wr_in && addr_in == sas_pkg::OFF_MASK && wdata_in[2:0] == 3'h0;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !irq_out && rdata_out == 32'h0)
    else $error("outputs not cleared by reset");
  chk_sar_rate: assert property ($rose(sar_clk_out) |=> (!$rose(sar_clk_out)) [*2])
    else $error("converter clock too fast");
  chk_rd_hole: assert property (rd_in && addr_in == 6'h08 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rd_in |=> $stable(rdata_out))
    else $error("read data changed without a read");
  chk_ref_sel: assert property (wr_in && addr_in == sas_pkg::OFF_CTRL |=> ref_sel_out == $past(wdata_in[5:4]))
    else $error("reference select not applied");
  chk_mask_off: assert property (s_mask_off |-> ##[1:2] !irq_out)
    else $error("masked interrupt still high");
  chk_mux_hold: assert property (sample_out ##1 sample_out |-> $stable(mux_sel_out))
    else $error("channel moved during aperture");
  chk_lp_stop: assert property (s_lp_held |-> !sample_out)
    else $error("sampling in deep low power");
endmodule // sas_seq_chk
bind sas_seq sas_seq_chk i_chk (.core_clk_in(core_clk_in), .srst_in(srst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .deep_lp_in(deep_lp_in), .sar_clk_out(sar_clk_out), .mux_sel_out(mux_sel_out),
  .sample_out(sample_out), .ref_sel_out(ref_sel_out), .irq_out(irq_out));

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module tb_top;
  logic        core_clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        deep_lp_in = 1'b0;
  logic [5:0]  addr_in = 6'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        cmp_in, sar_clk_out, temp_sel_out, sample_out, irq_out;
  logic [31:0] rdata_out, rd_q;
  logic [11:0] dac_out;
  logic [2:0]  mux_sel_out, last_ch;
  logic [1:0]  ref_sel_out;
  logic [7:0]  seen = 8'h00;
  logic        seen_temp = 1'b0;
  int          failures = 0, compares = 0, run_len = 0, k;
  int          len [8];
  sas_seq i_dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .deep_lp_in(deep_lp_in), .cmp_in(cmp_in), .sar_clk_out(sar_clk_out), .dac_out(dac_out),
    .mux_sel_out(mux_sel_out), .temp_sel_out(temp_sel_out), .sample_out(sample_out),
    .ref_sel_out(ref_sel_out), .irq_out(irq_out));
  sas_ana_model i_ana (.core_clk_in(core_clk_in), .dac_in(dac_out), .mux_sel_in(mux_sel_out),
    .temp_sel_in(temp_sel_out), .sample_in(sample_out), .cmp_out(cmp_in));
  initial
  begin
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // aperture watcher: channels seen and aperture length per channel
  always @(posedge core_clk_in)
  begin
    if (sample_out === 1'b1)
    begin
      seen[mux_sel_out] = 1'b1;
      seen_temp = seen_temp | temp_sel_out;
      last_ch = mux_sel_out;
      run_len++;
    end
    else if (run_len > 0)
    begin
      len[last_ch] = run_len;
      run_len = 0;
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge core_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1 rd_q = rdata_out;
  endtask
  // polls status; a bound keeps a stuck sequencer from hanging the run
  task automatic wait_stat(input int b);
    for (k = 0; k < 400; k++)
    begin
      rd(sas_pkg::OFF_STAT);
      if (rd_q[b] === 1'b1) break;
    end
    if (k == 400)
    begin
      `CHK(k, 0, "status wait timed out")
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    srst_in <= 1'b0;
    rd(sas_pkg::OFF_LIMHI);
    `CHK(rd_q[11:0], sas_pkg::LIMHI_RST, "high limit reset")
    rd(sas_pkg::OFF_SAMP + 6'h03);
    `CHK(rd_q[7:0], sas_pkg::SAMP_RST, "sample time reset")
    wr(6'h08, 32'hFFFF);
    rd(6'h08);
    `CHK(rd_q, 32'h0, "unmapped read")
    for (k = 0; k < 4; k++)
    begin
      wr(sas_pkg::OFF_CTRL, 32'(k) << 4);
      `CHK(ref_sel_out, 2'(k), "reference select")
    end
    wr(sas_pkg::OFF_MASK, 32'h7);
    wr(sas_pkg::OFF_CHEN, 32'hA5);
    wr(sas_pkg::OFF_SAMP + 6'h07, 32'h50);
    wr(sas_pkg::OFF_CTRL, 32'h09);
    wait_stat(sas_pkg::IRQ_SCAN);
    `CHK(seen, 8'hA5, "enabled channels scanned")
    `CHK(len[7] > len[5], 1'b1, "per-channel aperture")
    for (int c = 0; c < 8; c++)
      if (c inside {0, 2, 5, 7})
      begin
        rd(sas_pkg::OFF_RES + 6'(c));
        `CHK(rd_q[11:0], 12'(12'h1F0 + 12'h150 * c), "channel result")
      end
    rd(sas_pkg::OFF_STATE);
    `CHK(rd_q[15:5], {8'hA5, 3'h0}, "valid flags and restart channel")
    wr(sas_pkg::OFF_STAT, 32'h7);
    wr(sas_pkg::OFF_LIMHI, 32'h100);
    wr(sas_pkg::OFF_FWSEL, 32'h7);
    seen = 8'h00;
    wr(sas_pkg::OFF_CTRL, 32'h0B);
    wait_stat(sas_pkg::IRQ_RANGE);
    `CHK(irq_out, 1'b1, "out of range interrupt")
    `CHK(seen, 8'h80, "firmware channel")
    wr(sas_pkg::OFF_MASK, 32'h0);
    `CHK(irq_out, 1'b0, "masked interrupt")
    wr(sas_pkg::OFF_STAT, 32'h7);
    rd(sas_pkg::OFF_STAT);
    `CHK(rd_q[2:0], 3'h0, "status cleared")
    wr(sas_pkg::OFF_CTRL, 32'h4B);
    wait_stat(sas_pkg::IRQ_DONE);
    `CHK(seen_temp, 1'b1, "temperature input")
    deep_lp_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    seen = 8'h00;
    wr(sas_pkg::OFF_CTRL, 32'h0D);
    repeat (200) @(posedge core_clk_in);
    `CHK(seen, 8'h00, "idle in deep low power")
    print_verdict();
  end
endmodule // tb_top
